// ### rtl/fsp_regs.svh
// register layout, reset values and timing constants of the flash protection block
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_OP_WRITE_ENABLE_CMD 8'h06
`define FSP_OP_WRITE_DISABLE_CMD 8'h04
`define FSP_OP_RDSR1 8'h05
`define FSP_OP_RDSR2 8'h35
`define FSP_OP_STATUS_WRITE_CMD 8'h01
`define FSP_OP_PP 8'h02
`define FSP_OP_SE 8'h20
`define FSP_OP_BE32 8'h52
`define FSP_OP_BE64 8'hd8
`define FSP_OP_CE 8'h60
`define FSP_OP_CE2 8'hc7
`define FSP_OP_SUSP 8'h75
`define FSP_OP_RESUME 8'h7a
`define FSP_OP_RSTEN 8'h66
`define FSP_OP_RST 8'h99
`define FSP_BIT_WIP 0
`define FSP_BIT_WEL 1
`define FSP_BIT_BP_LO 2
`define FSP_BIT_SR_PROTECT_LO 7
`define FSP_BIT_SR_PROTECT_HI 8
`define FSP_BIT_QE 9
`define FSP_BIT_PROGRAM_SUSPENDED 10
`define FSP_BIT_LB_LO 11
`define FSP_BIT_CMP 14
`define FSP_BIT_ERASE_SUSPENDED 15
`define FSP_NV_RESET 16'h0000
`define FSP_ARRAY_TOP 24'h3fffff
`define FSP_BUSY_NS 1000
`define FSP_CLK_NS 25
`define FSP_BUSY_CYC ((`FSP_BUSY_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`endif

// ### rtl/fsp_pkg.sv
// types of the flash protection block
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_BUSY = 2'b01,
        FSP_DONE = 2'b11
    } fsp_state_t;
    typedef enum logic [2:0] {
        FSP_OP_NONE = 3'h0,
        FSP_OP_WSR = 3'h1,
        FSP_OP_PROG = 3'h2,
        FSP_OP_ERASE = 3'h3,
        FSP_OP_CHIP = 3'h4
    } fsp_op_t;
endpackage

// ### rtl/fsp_prot_decode.sv
// decoder of protect bits into a protected address window
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_prot_decode (
    input wire logic [4:0] bp,
    input wire logic cmp,
    output logic prot_any,
    output logic [23:0] prot_lo,
    output logic [23:0] prot_hi
);
    logic [23:0] sz;
    logic [2:0] c;
    always_comb begin
        c = bp[2:0];
        sz = 24'h000000;
        if (!bp[4]) begin
            // 64 kb granules, doubling
            case (c)
                3'h1: sz = 24'h010000;
                3'h2: sz = 24'h020000;
                3'h3: sz = 24'h040000;
                3'h4: sz = 24'h080000;
                3'h5: sz = 24'h100000;
                3'h6: sz = 24'h200000;
                default: sz = 24'h000000;
            endcase
        end else begin
            // 4 kb granules, capped at 32 kb
            case (c)
                3'h1: sz = 24'h001000;
                3'h2: sz = 24'h002000;
                3'h3: sz = 24'h004000;
                3'h4, 3'h5, 3'h6: sz = 24'h008000;
                default: sz = 24'h000000;
            endcase
        end
        prot_any = 1'b1;
        prot_lo = 24'h000000;
        prot_hi = `FSP_ARRAY_TOP;
        if (c == 3'h7) begin
            prot_any = !cmp; // [R2] [R16]
        end else if (c == 3'h0) begin
            prot_any = cmp; // [R1] [R16]
        end else if (!cmp) begin
            if (bp[3]) prot_hi = sz - 24'h000001; // [R7] [R16]
            else prot_lo = `FSP_ARRAY_TOP + 24'h000001 - sz;
        end else begin
            // complement of the same granule at the opposite end
            if (bp[3]) prot_lo = sz; // [R4] [R6]
            else prot_hi = `FSP_ARRAY_TOP - sz; // [R3] [R5]
        end
    end
endmodule

// ### rtl/fsp_sync.sv
// two flop synchroniser for single level signals
`timescale 1ns/1ps
module fsp_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic s1_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_reg <= d;
            q <= s1_reg;
        end
    end
endmodule

// ### rtl/fsp_status_prot.sv
// status register pair, write enable latch and array write gating
//
// Summary of operation
// R1 - complement set, low protect bits 000: whole array protected.
// R2 - complement set, low protect bits 111: nothing protected.
// R3 - complement, upper bits 00: protect from zero up to shrinking end.
// R4 - complement, upper bits 01: protect from rising start to top.
// R5 - complement, upper bits 10: from zero to top less 4k..32k.
// R6 - complement, upper bits 11: from 4k..32k start up to top.
// R7 - no complement, 11011 protects 16k bottom, 1110x/11110 32k bottom.
// R8 - low byte: protect lock, five protect bits, latch, busy.
// R9 - high byte: erase susp, complement, locks, prog susp, quad, lock.
// R10 - busy, latch, suspends read only; locks one-time programmable.
// R11 - busy reads one during any program, erase or status write.
// R12 - with latch clear, status write, program, erase are refused.
// R13 - protect bits written by status write unless hardware locked.
// R14 - program and erase into protected region are rejected.
// R15 - chip erase runs only when nothing protected by low bits.
// R16 - no complement: low bits 000 none, 111 whole array.
// R17 - write enable sets latch; cleared by reset, disable, completion.
// R18 - protect bits 01 with write protect pin low lock status.
// R19 - suspend sets a flag, resume or reset clears it.
// R20 - full 24-bit target compared against bounds before starting.
// R21 - status write leaves volatile bits unchanged.
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_status_prot (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic write_protect_pin_b,
    output logic [7:0] status_low_byte,
    output logic [7:0] status_high_byte,
    output logic busy_out,
    output logic cmd_refused
);
    // command words cross from link_clk by a toggle handshake
    logic lk_tog_reg;
    logic [7:0] lk_op_reg;
    logic [23:0] lk_addr_reg;
    logic [15:0] lk_data_reg;
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_tog_reg <= 1'b0;
            lk_op_reg <= 8'h00;
            lk_addr_reg <= 24'h000000;
            lk_data_reg <= 16'h0000;
        end else if (cmd_valid) begin
            // words held stable for at least three ref_clk periods
            lk_tog_reg <= !lk_tog_reg;
            lk_op_reg <= cmd_op;
            lk_addr_reg <= cmd_addr;
            lk_data_reg <= cmd_data;
        end
    end

    logic tog_s;
    logic tog_d_reg;
    logic wp_s;
    fsp_sync u_tog (
        .clk(ref_clk),
        .rst_b(rst_b),
        .d(lk_tog_reg),
        .q(tog_s)
    );
    fsp_sync u_wp (
        .clk(ref_clk),
        .rst_b(rst_b),
        .d(write_protect_pin_b),
        .q(wp_s)
    );
    logic cmd_stb;
    assign cmd_stb = tog_s ^ tog_d_reg;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) tog_d_reg <= 1'b0;
        else tog_d_reg <= tog_s;
    end

    // non-volatile bits kept in flops, then the volatile latch, suspend flags and sequencer state
    logic [4:0] bp_reg;
    logic cmp_reg;
    logic sr_protect_lo_reg;
    logic sr_protect_hi_reg;
    logic qe_reg;
    logic [2:0] lb_reg;
    logic wel_reg;
    logic erase_suspended_reg;
    logic program_suspended_reg;
    logic rst_arm_reg;
    fsp_pkg::fsp_state_t state_reg;
    fsp_pkg::fsp_op_t op_reg;
    logic [15:0] wr_data_reg;
    logic [15:0] cnt_reg;

    logic prot_any;
    logic [23:0] prot_lo;
    logic [23:0] prot_hi;
    fsp_prot_decode u_dec (
        .bp(bp_reg),
        .cmp(cmp_reg),
        .prot_any(prot_any),
        .prot_lo(prot_lo),
        .prot_hi(prot_hi)
    );

    function automatic logic is_erase(input logic [7:0] op);
        is_erase = op == `FSP_OP_SE || op == `FSP_OP_BE32 ||
            op == `FSP_OP_BE64;
    endfunction
    function automatic logic is_chip(input logic [7:0] op);
        is_chip = op == `FSP_OP_CE || op == `FSP_OP_CE2;
    endfunction

    logic idle;
    logic hw_lock;
    logic hit;
    logic chip_ok;
    logic start_wsr;
    logic start_prog;
    logic start_erase;
    logic start_chip;
    logic refuse;
    logic sw_reset;
    assign idle = state_reg == fsp_pkg::FSP_IDLE;
    // hardware lock on 01 with pin low; 1x also locks until reset
    assign hw_lock = (sr_protect_lo_reg && !sr_protect_hi_reg && !wp_s) || sr_protect_hi_reg; // [R18]
    assign hit = prot_any && lk_addr_reg >= prot_lo &&
        lk_addr_reg <= prot_hi; // [R20] [R14]
    assign chip_ok = (bp_reg[2:0] == 3'h0 && !cmp_reg) ||
        (bp_reg[2:0] == 3'h7 && cmp_reg); // [R15]
    assign start_wsr = cmd_stb && idle && wel_reg && !hw_lock &&
        lk_op_reg == `FSP_OP_STATUS_WRITE_CMD; // [R12] [R13]
    assign start_prog = cmd_stb && idle && wel_reg && !hit &&
        lk_op_reg == `FSP_OP_PP; // [R12] [R14]
    assign start_erase = cmd_stb && idle && wel_reg && !hit &&
        is_erase(lk_op_reg); // [R12] [R14]
    assign start_chip = cmd_stb && idle && wel_reg && chip_ok &&
        is_chip(lk_op_reg); // [R12] [R15]
    assign refuse = cmd_stb && !(start_wsr || start_prog || start_erase ||
        start_chip) && (lk_op_reg == `FSP_OP_STATUS_WRITE_CMD ||
        lk_op_reg == `FSP_OP_PP || is_erase(lk_op_reg) ||
        is_chip(lk_op_reg));
    assign sw_reset = cmd_stb && rst_arm_reg && lk_op_reg == `FSP_OP_RST;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rst_arm_reg <= 1'b0;
        else if (cmd_stb) rst_arm_reg <= lk_op_reg == `FSP_OP_RSTEN;
    end

    // busy sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= fsp_pkg::FSP_IDLE;
            op_reg <= fsp_pkg::FSP_OP_NONE;
            cnt_reg <= 16'h0000;
            wr_data_reg <= 16'h0000;
        end else begin
            case (state_reg)
                fsp_pkg::FSP_IDLE: begin
                    cnt_reg <= 16'(`FSP_BUSY_CYC);
                    wr_data_reg <= lk_data_reg;
                    if (start_wsr) op_reg <= fsp_pkg::FSP_OP_WSR;
                    else if (start_prog) op_reg <= fsp_pkg::FSP_OP_PROG;
                    else if (start_erase) op_reg <= fsp_pkg::FSP_OP_ERASE;
                    else if (start_chip) op_reg <= fsp_pkg::FSP_OP_CHIP;
                    if (start_wsr || start_prog || start_erase || start_chip)
                        state_reg <= fsp_pkg::FSP_BUSY;
                end
                fsp_pkg::FSP_BUSY: begin
                    // a program or erase suspend freezes the countdown until resume
                    if (!(erase_suspended_reg || program_suspended_reg)) cnt_reg <= cnt_reg - 16'h1;
                    if (cnt_reg == 16'h1 && !(erase_suspended_reg || program_suspended_reg))
                        state_reg <= fsp_pkg::FSP_DONE;
                    if (sw_reset) state_reg <= fsp_pkg::FSP_IDLE;
                end
                fsp_pkg::FSP_DONE: begin
                    state_reg <= fsp_pkg::FSP_IDLE;
                    op_reg <= fsp_pkg::FSP_OP_NONE;
                end
                default: state_reg <= fsp_pkg::FSP_IDLE;
            endcase
        end
    end

    // writable bits update at completion of a status write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bp_reg <= 5'(`FSP_NV_RESET >> `FSP_BIT_BP_LO);
            cmp_reg <= 1'b0;
            sr_protect_lo_reg <= 1'b0;
            sr_protect_hi_reg <= 1'b0;
            qe_reg <= 1'b0;
            lb_reg <= 3'h0;
        end else if (state_reg == fsp_pkg::FSP_DONE &&
                op_reg == fsp_pkg::FSP_OP_WSR) begin
            bp_reg <= wr_data_reg[`FSP_BIT_SR_PROTECT_LO-1:`FSP_BIT_BP_LO]; // [R13]
            sr_protect_lo_reg <= wr_data_reg[`FSP_BIT_SR_PROTECT_LO]; // [R10]
            sr_protect_hi_reg <= wr_data_reg[`FSP_BIT_SR_PROTECT_HI];
            qe_reg <= wr_data_reg[`FSP_BIT_QE];
            cmp_reg <= wr_data_reg[`FSP_BIT_CMP];
            lb_reg <= lb_reg | wr_data_reg[`FSP_BIT_CMP-1:`FSP_BIT_LB_LO]; // [R10]
        end
    end

    // write enable latch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) wel_reg <= 1'b0;
        else if (sw_reset) wel_reg <= 1'b0; // [R17]
        else if (state_reg == fsp_pkg::FSP_DONE) wel_reg <= 1'b0; // [R17]
        else if (cmd_stb && idle && lk_op_reg == `FSP_OP_WRITE_ENABLE_CMD)
            wel_reg <= 1'b1; // [R17]
        else if (cmd_stb && lk_op_reg == `FSP_OP_WRITE_DISABLE_CMD) wel_reg <= 1'b0; // [R17]
    end

    // suspend flags
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            erase_suspended_reg <= 1'b0;
            program_suspended_reg <= 1'b0;
        end else if (sw_reset || (cmd_stb &&
                lk_op_reg == `FSP_OP_RESUME)) begin
            erase_suspended_reg <= 1'b0; // [R19]
            program_suspended_reg <= 1'b0;
        end else if (cmd_stb && lk_op_reg == `FSP_OP_SUSP &&
                state_reg == fsp_pkg::FSP_BUSY) begin
            erase_suspended_reg <= op_reg == fsp_pkg::FSP_OP_ERASE ||
                op_reg == fsp_pkg::FSP_OP_CHIP; // [R19]
            program_suspended_reg <= op_reg == fsp_pkg::FSP_OP_PROG; // [R19]
        end
    end

    // registered outputs; volatile bits come only from internal state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_low_byte <= 8'h00;
            status_high_byte <= 8'h00;
            busy_out <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            status_low_byte <= {sr_protect_lo_reg, bp_reg, wel_reg,
                state_reg != fsp_pkg::FSP_IDLE}; // [R8] [R11] [R21]
            status_high_byte <= {erase_suspended_reg, cmp_reg, lb_reg, program_suspended_reg,
                qe_reg, sr_protect_hi_reg}; // [R9]
            busy_out <= state_reg != fsp_pkg::FSP_IDLE; // [R11]
            cmd_refused <= refuse; // [R12]
        end
    end

    property p_refuse_nowel;
        @(posedge ref_clk) disable iff (!rst_b)
        cmd_stb && !wel_reg && lk_op_reg == `FSP_OP_PP |=> cmd_refused;
    endproperty
    a_refuse_nowel: assert property (p_refuse_nowel) // [R12]
        else $error("program accepted without latch");

    property p_busy;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(state_reg == fsp_pkg::FSP_BUSY) |=> busy_out[*3];
    endproperty
    a_busy: assert property (p_busy) // [R11]
        else $error("busy not shown during operation");

    property p_wel_clr;
        @(posedge ref_clk) disable iff (!rst_b)
        state_reg == fsp_pkg::FSP_DONE |=> !wel_reg ##1 !status_low_byte[1];
    endproperty
    a_wel_clr: assert property (p_wel_clr) // [R17]
        else $error("latch not cleared after operation");

    property p_hit;
        @(posedge ref_clk) disable iff (!rst_b)
        cmd_stb && idle && wel_reg && hit && lk_op_reg == `FSP_OP_PP
        |=> state_reg == fsp_pkg::FSP_IDLE && cmd_refused;
    endproperty
    a_hit: assert property (p_hit) // [R14]
        else $error("protected program started");

    property p_chip;
        @(posedge ref_clk) disable iff (!rst_b)
        start_chip |-> (bp_reg[2:0] == 3'h0) != cmp_reg;
    endproperty
    a_chip: assert property (p_chip) // [R15]
        else $error("chip erase with protection");

    property p_cmp0;
        @(posedge ref_clk) disable iff (!rst_b)
        cmp_reg && bp_reg[2:0] == 3'h0 |-> prot_any && prot_lo == 24'h0 &&
        prot_hi == `FSP_ARRAY_TOP;
    endproperty
    a_cmp0: assert property (p_cmp0) // [R1]
        else $error("complement all region wrong");

    property p_cmp7;
        @(posedge ref_clk) disable iff (!rst_b)
        cmp_reg && bp_reg[2:0] == 3'h7 |-> !prot_any;
    endproperty
    a_cmp7: assert property (p_cmp7) // [R2]
        else $error("complement none region wrong");

    property p_lock;
        @(posedge ref_clk) disable iff (!rst_b)
        hw_lock |-> !start_wsr;
    endproperty
    a_lock: assert property (p_lock) // [R18]
        else $error("status written while locked");

    property p_lb;
        @(posedge ref_clk) disable iff (!rst_b)
        $past(lb_reg) != 3'h0 |-> (lb_reg & $past(lb_reg)) == $past(lb_reg);
    endproperty
    a_lb: assert property (p_lb) // [R10]
        else $error("lock bit cleared");

    // busy bit seen by the host must cover every cycle of an operation
    property p_wip;
        @(posedge ref_clk) disable iff (!rst_b)
        !idle |=> status_low_byte[0];
    endproperty
    a_wip: assert property (p_wip) // [R11]
        else $error("busy bit low during operation");

    // any visible start must have been preceded by a set latch
    property p_wel_gate;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(busy_out) |-> $past(wel_reg, 2);
    endproperty
    a_wel_gate: assert property (p_wel_gate) // [R12]
        else $error("operation started without latch");

    property p_bp_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        !(state_reg == fsp_pkg::FSP_DONE && op_reg == fsp_pkg::FSP_OP_WSR)
        |=> $stable(bp_reg) && $stable(cmp_reg);
    endproperty
    a_bp_hold: assert property (p_bp_hold) // [R13]
        else $error("protect bits moved outside status write");

    property p_ro_sus;
        @(posedge ref_clk) disable iff (!rst_b)
        state_reg == fsp_pkg::FSP_DONE && op_reg == fsp_pkg::FSP_OP_WSR &&
        !cmd_stb |=> $stable(erase_suspended_reg) && $stable(program_suspended_reg);
    endproperty
    a_ro_sus: assert property (p_ro_sus) // [R21]
        else $error("status write changed suspend flags");

    c_wsr: cover property (@(posedge ref_clk) start_wsr);
    c_chip: cover property (@(posedge ref_clk) start_chip);
    c_prog: cover property (@(posedge ref_clk) start_prog);
    c_refuse: cover property (@(posedge ref_clk) cmd_refused);
    c_susp: cover property (@(posedge ref_clk) erase_suspended_reg);
endmodule

// ### verification/fsp_host_model.sv
// host controller model that issues one command per link clock burst
`timescale 1ns/1ps
module fsp_host_model (
    output logic link_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_op,
    output logic [23:0] cmd_addr,
    output logic [15:0] cmd_data,
    output logic write_protect_pin_b
);
    // link clock stands still between commands, as a real host's would
    initial begin
        link_clk = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_addr = 24'h000000;
        cmd_data = 16'h0000;
        write_protect_pin_b = 1'b1;
    end
    task automatic clocks(input int n);
        repeat (n) begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
    endtask
    // released fields carry the inverse so stale values never look live
    task automatic send(input logic [7:0] op, input logic [23:0] addr,
                        input logic [15:0] data);
        #3;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = addr;
        cmd_data = data;
        clocks(1);
        cmd_valid = 1'b0;
        cmd_op = ~op;
        cmd_addr = ~addr;
        cmd_data = ~data;
        clocks(4);
    endtask
    task automatic set_pin(input logic v);
        write_protect_pin_b = v;
    endtask
endmodule

// ### verification/test_flash_status_and_array_protection.sv
// self-checking bench for the status and array protection block
`timescale 1ns/1ps
`include "fsp_regs.svh"
`define CHK(got, exp, msg) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected at %0t: %s", $time, msg); \
        end \
    end
module test_flash_status_and_array_protection;
    logic ref_clk;
    logic rst_b;
    logic link_clk;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [23:0] cmd_addr;
    logic [15:0] cmd_data;
    logic write_protect_pin_b;
    logic [7:0] status_low_byte;
    logic [7:0] status_high_byte;
    logic busy_out;
    logic cmd_refused;
    logic busy_q = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;
    int refusals = 0;
    int starts = 0;
    int run_len = 0;
    int last_len = 0;
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    fsp_status_prot fsp_status_prot_inst (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .link_clk(link_clk),
        .cmd_valid(cmd_valid),
        .cmd_op(cmd_op),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data),
        .write_protect_pin_b(write_protect_pin_b),
        .status_low_byte(status_low_byte),
        .status_high_byte(status_high_byte),
        .busy_out(busy_out),
        .cmd_refused(cmd_refused)
    );
    fsp_host_model fsp_host_model_inst (
        .link_clk(link_clk),
        .cmd_valid(cmd_valid),
        .cmd_op(cmd_op),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data),
        .write_protect_pin_b(write_protect_pin_b)
    );
    // refusal pulses last one cycle, so they are tallied here, not polled
    always @(posedge ref_clk) begin
        busy_q <= busy_out;
        if (cmd_refused === 1'b1)
            refusals <= refusals + 1;
        if (busy_out === 1'b1 && busy_q !== 1'b1)
            starts <= starts + 1;
        if (busy_out === 1'b1)
            run_len <= run_len + 1;
        else if (run_len != 0) begin
            last_len <= run_len;
            run_len <= 0;
        end
    end
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic settle;
        int n;
        n = 0;
        repeat (8) @(negedge ref_clk);
        while (busy_out !== 1'b0 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 400) begin
            mismatches++;
            $display("unexpected at %0t: busy never ended", $time);
            wrap_up();
        end
        // one more edge so the run-length tally has closed the last run
        @(negedge ref_clk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] addr,
                       input logic [15:0] data);
        @(negedge ref_clk);
        fsp_host_model_inst.send(op, addr, data);
        settle();
    endtask
    // result 2'b10 means started, 2'b01 means refused
    task automatic try_cmd(input logic [7:0] op, input logic [23:0] addr,
                           input logic [15:0] data, output logic [1:0] res);
        int s0;
        int r0;
        cmd(`FSP_OP_WRITE_ENABLE_CMD, 24'h000000, 16'h0000);
        s0 = starts;
        r0 = refusals;
        cmd(op, addr, data);
        res = {starts == s0 + 1, refusals == r0 + 1};
    endtask
    task automatic t_reset;
        `CHK(status_low_byte, 8'h00, "low byte after reset");
        `CHK(status_high_byte, 8'h00, "high byte after reset");
        `CHK(busy_out, 1'b0, "busy after reset");
    endtask
    task automatic t_latch;
        int r0;
        cmd(`FSP_OP_WRITE_ENABLE_CMD, 24'h000000, 16'h0000);
        `CHK(status_low_byte[1], 1'b1, "latch not set");
        cmd(`FSP_OP_WRITE_DISABLE_CMD, 24'h000000, 16'h0000);
        `CHK(status_low_byte[1], 1'b0, "latch not cleared");
        r0 = refusals;
        cmd(`FSP_OP_PP, 24'h000000, 16'h0000);
        `CHK(refusals, r0 + 1, "program without latch");
        cmd(`FSP_OP_WRITE_ENABLE_CMD, 24'h000000, 16'h0000);
        cmd(`FSP_OP_RSTEN, 24'h000000, 16'h0000);
        cmd(`FSP_OP_RST, 24'h000000, 16'h0000);
        `CHK(status_low_byte[1], 1'b0, "latch kept over reset");
    endtask
    // read-only bits offered as ones must stay zero
    task automatic t_status;
        logic [1:0] res;
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'hc67f, res);
        `CHK(res, 2'b10, "status write refused");
        `CHK(status_low_byte, 8'h7c, "low byte layout");
        `CHK(status_high_byte, 8'h42, "high byte layout");
        `CHK(last_len, `FSP_BUSY_CYC + 1, "busy length");
    endtask
    task automatic run_case(input logic [5:0] mode, input logic [7:0] op,
                            input logic [23:0] addr, input logic acc);
        logic [1:0] res;
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000,
                {1'b0, mode[5], 7'h00, mode[4:0], 2'b00}, res);
        `CHK(res, 2'b10, "protect write refused");
        try_cmd(op, addr, 16'h0000, res);
        `CHK(res, acc ? 2'b10 : 2'b01, "protection decision");
    endtask
    task automatic t_map;
        run_case(6'h20, `FSP_OP_PP, 24'h3fffff, 1'b0);
        run_case(6'h38, `FSP_OP_PP, 24'h000000, 1'b0);
        run_case(6'h3f, `FSP_OP_PP, 24'h000000, 1'b1);
        run_case(6'h27, `FSP_OP_CE, 24'h000000, 1'b1);
        run_case(6'h21, `FSP_OP_PP, 24'h3effff, 1'b0);
        run_case(6'h21, `FSP_OP_SE, 24'h3f0000, 1'b1);
        run_case(6'h2e, `FSP_OP_PP, 24'h1fffff, 1'b1);
        run_case(6'h2e, `FSP_OP_BE64, 24'h200000, 1'b0);
        run_case(6'h34, `FSP_OP_PP, 24'h3f7fff, 1'b0);
        run_case(6'h35, `FSP_OP_BE32, 24'h3f8000, 1'b1);
        run_case(6'h39, `FSP_OP_PP, 24'h000fff, 1'b1);
        run_case(6'h39, `FSP_OP_PP, 24'h001000, 1'b0);
        run_case(6'h1b, `FSP_OP_PP, 24'h003fff, 1'b0);
        run_case(6'h1b, `FSP_OP_PP, 24'h004000, 1'b1);
        run_case(6'h1d, `FSP_OP_PP, 24'h007fff, 1'b0);
        run_case(6'h1e, `FSP_OP_PP, 24'h008000, 1'b1);
        run_case(6'h17, `FSP_OP_PP, 24'h000000, 1'b0);
        run_case(6'h17, `FSP_OP_CE, 24'h000000, 1'b0);
        run_case(6'h20, `FSP_OP_CE2, 24'h000000, 1'b0);
        run_case(6'h18, `FSP_OP_CE2, 24'h000000, 1'b1);
    endtask
    task automatic t_lock;
        logic [1:0] res;
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'h0080, res);
        fsp_host_model_inst.set_pin(1'b0);
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'h0004, res);
        `CHK(res, 2'b01, "write under pin lock");
        `CHK(status_low_byte[7:2], 6'h20, "locked bits moved");
        fsp_host_model_inst.set_pin(1'b1);
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'h0000, res);
        `CHK(res, 2'b10, "write after unlock");
    endtask
    // suspend lands well inside the busy time, before the count ends
    task automatic t_susp(input logic [7:0] op, input int b);
        cmd(`FSP_OP_WRITE_ENABLE_CMD, 24'h000000, 16'h0000);
        @(negedge ref_clk);
        fsp_host_model_inst.send(op, 24'h100000, 16'h0000);
        `CHK(status_low_byte[0], 1'b1, "busy flag low");
        fsp_host_model_inst.send(`FSP_OP_SUSP, 24'h000000, 16'h0000);
        repeat (8) @(negedge ref_clk);
        `CHK(status_high_byte[b], 1'b1, "suspend flag low");
        fsp_host_model_inst.send(`FSP_OP_RESUME, 24'h000000, 16'h0000);
        repeat (8) @(negedge ref_clk);
        `CHK(status_high_byte[b], 1'b0, "suspend flag kept");
        settle();
        `CHK(status_low_byte[1:0], 2'b00, "latch or busy left");
    endtask
    // lock bits are one-time: a later zero must not clear them
    task automatic t_otp;
        logic [1:0] res;
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'h0800, res);
        `CHK(status_high_byte, 8'h08, "lock bit not set");
        try_cmd(`FSP_OP_STATUS_WRITE_CMD, 24'h000000, 16'h0000, res);
        `CHK(status_high_byte[3], 1'b1, "lock bit cleared");
    endtask
    initial begin
        rst_b = 1'b0;
        fork
            fsp_host_model_inst.clocks(4);
            repeat (6) @(negedge ref_clk);
        join
        rst_b = 1'b1;
        fsp_host_model_inst.clocks(1);
        t_reset();
        t_latch();
        t_status();
        t_map();
        t_lock();
        t_susp(`FSP_OP_PP, 2);
        t_susp(`FSP_OP_SE, 7);
        t_otp();
        wrap_up();
    end
endmodule
